//--- design/isu_top.sv
`timescale 1ns/1ns
// Function
// - fetch linear address, read only
// - fetch physical address, upper bits zero
// - 27-bit counter runs when enabled, not valid, no op in flight
// - bit 19 picks clocks or dispatched ops
// - counter match tags op two cycles later
// - maximum count from two control fields
// - retire writes sample, sets valid bit
// - interrupt only after sample is stored
// - counter holds while valid is set
// - abort reloads counter low bits randomly
// - current count readable, loaded on clear
// - bit 17 enables op sampling
// - miss filter gates the interrupt
// - op address captured with invalid flag
// - access only via register port
// - fetch valid on completion or abort
// - fetch physical valid qualifies address
// - address invalid flag when address bad
module isu_top
    import isu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // model-specific register port
    input wire logic REG_RD_I,
    input wire logic REG_WR_I,
    input wire logic [2:0] REG_IDX_I,
    input wire logic [63:0] REG_WDATA_I,
    output logic [63:0] REG_RDATA_O,
    output logic REG_ACK_O,
    output logic REG_ERR_O,
    // fetch side of the pipeline
    input wire logic FETCH_DONE_I,
    input wire logic FETCH_PHYS_OK_I,
    input wire logic [63:0] FETCH_LIN_I,
    input wire logic [51:0] FETCH_PHYS_I,
    // op side of the pipeline
    input wire logic OP_DISPATCH_I,
    input wire logic OP_RETIRE_I,
    input wire logic OP_ABORT_I,
    input wire logic OP_MISS_I,
    input wire logic OP_ADDR_BAD_I,
    input wire logic [63:0] OP_LIN_I,
    output logic OP_TAG_O,
    // request to the local interrupt controller
    output logic IRQ_O
);
    isu_state_t state;
    isu_state_t next_state;
    logic [ISU_CNT_W-1:0] cnt;
    logic [ISU_CNT_W-1:0] next_cnt;
    logic [ISU_MAX_W-1:0] max_cnt;           // concatenated maximum count
    logic [ISU_MAX_W-1:0] next_max_cnt;
    logic src;                               // 1: count dispatched ops
    logic next_src;
    logic op_val;
    logic next_op_val;
    logic op_en;
    logic next_op_en;
    logic miss_only;
    logic next_miss_only;
    logic [63:0] op_lin;
    logic [63:0] next_op_lin;
    logic addr_inv;
    logic next_addr_inv;
    logic tag;
    logic next_tag;
    logic irq;
    logic next_irq;
    logic [63:0] rdata;
    logic [63:0] next_rdata;
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [6:0] rnd;                         // random abort reload
    logic f_clear;                           // software clears fetch flags
    logic [63:0] f_lin;
    logic [51:0] f_phys;
    logic f_val;
    logic f_pval;
    logic wr_ctl;
    logic [63:0] ctl_view;                   // control word as software reads it
    logic irq_pend_done;                     // request already raised for this sample
    logic next_irq_pend_done;
    logic miss_seen;                         // tagged op missed last level cache
    logic next_miss_seen;

    // returns the control word as software sees it
    function automatic logic [63:0] isu_ctl_word(
        input logic [ISU_CNT_W-1:0] c,
        input logic [ISU_MAX_W-1:0] m,
        input logic s,
        input logic v,
        input logic e,
        input logic f
    );
        logic [63:0] w;
        w = 64'h0;
        w[ISU_CUR_MSB:ISU_CUR_LSB] = c;
        // maximum count split in two fields
        w[ISU_MAXHI_MSB:ISU_MAXHI_LSB] = m[22:16];
        w[ISU_MAXLO_MSB:0] = m[15:0];
        w[ISU_SRC_BIT] = s;
        w[ISU_VAL_BIT] = v;
        w[ISU_EN_BIT] = e;
        w[ISU_MISS_BIT] = f;
        return w;
    endfunction

    // free-running source: hardware randomises only after an abort
    isu_lfsr u_lfsr (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .value_o(rnd)
    );

    // fetch flags clear only through a register write of the status index
    assign f_clear = REG_WR_I && (REG_IDX_I == ISU_REG_FETCH_STAT)
        && !REG_WDATA_I[ISU_FETCH_VAL_BIT];

    // fetch sample holder; fetch control and its counter live outside this block
    isu_capture u_capture (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .done_i(FETCH_DONE_I),
        .phys_ok_i(FETCH_PHYS_OK_I),
        .lin_i(FETCH_LIN_I),
        .phys_i(FETCH_PHYS_I),
        .clear_i(f_clear),
        .lin_o(f_lin),
        .phys_o(f_phys),
        .valid_o(f_val),
        .phys_valid_o(f_pval)
    );

    // control write strobe, decoded once for the engine
    assign wr_ctl = REG_WR_I && (REG_IDX_I == ISU_REG_OP_CTL);
    // software view of the control word, shared by the read path
    assign ctl_view = isu_ctl_word(cnt, max_cnt, src, op_val, op_en, miss_only);

    // op sampling engine: counter, tag, retire or abort, software writes
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_max_cnt = max_cnt;
        next_src = src;
        next_op_val = op_val;
        next_op_en = op_en;
        next_miss_only = miss_only;
        next_op_lin = op_lin;
        next_addr_inv = addr_inv;
        next_tag = 1'b0;
        next_irq = 1'b0;
        // count only when enabled and no sample pending
        if (op_en && !op_val && state == ISU_COUNT)
        begin
            if (!src || OP_DISPATCH_I)
                next_cnt = cnt + 27'h1;
        end
        unique case (state)
            ISU_COUNT:
            begin
                // a match lasts up to 16 counts; leaving count at once tags one op only
                // match on bits 26:4 enters ISU_TAG next cycle; the tag follows a cycle later
                if (op_en && !op_val && cnt[26:4] == max_cnt)
                    next_state = ISU_TAG;
            end
            ISU_TAG:
            begin
                next_tag = 1'b1;
                next_state = ISU_WAIT;
            end
            ISU_WAIT:
            begin
                if (OP_RETIRE_I)
                begin
                    next_op_val = 1'b1;
                    next_op_lin = OP_LIN_I;
                    next_addr_inv = OP_ADDR_BAD_I;
                    // the request itself follows from the stored flag below
                    next_state = ISU_COUNT;
                end
                else if (OP_ABORT_I)
                begin
                    // no sample, random low bits, keep counting
                    next_cnt = {20'h0, rnd};
                    next_state = ISU_COUNT;
                end
            end
            // illegal code 2'b10 falls back to counting
            default:
                next_state = ISU_COUNT;
        endcase
        // request only once valid is stored
        // miss filter gates the request
        // raised the cycle after valid becomes set, never in the same one
        if (op_val && !irq_pend_done && (!miss_only || miss_seen))
            next_irq = 1'b1;
        // control is changed only via the register port
        if (wr_ctl)
        begin
            next_op_en = REG_WDATA_I[ISU_EN_BIT];
            next_src = REG_WDATA_I[ISU_SRC_BIT];
            next_miss_only = REG_WDATA_I[ISU_MISS_BIT];
            next_max_cnt = {REG_WDATA_I[ISU_MAXHI_MSB:ISU_MAXHI_LSB],
                REG_WDATA_I[ISU_MAXLO_MSB:0]};
            // clearing valid loads the starting count
            if (!REG_WDATA_I[ISU_VAL_BIT] && !(state == ISU_WAIT && OP_RETIRE_I))
            begin
                next_op_val = 1'b0;
                next_cnt = REG_WDATA_I[ISU_CUR_MSB:ISU_CUR_LSB];
            end
            // disabling drops an op in flight
            if (!REG_WDATA_I[ISU_EN_BIT])
                next_state = ISU_COUNT;
        end
        // sample registers stay writable so software can restore them
        if (REG_WR_I && REG_IDX_I == ISU_REG_OP_LIN)
            next_op_lin = REG_WDATA_I;
        if (REG_WR_I && REG_IDX_I == ISU_REG_OP_DATA1)
            next_addr_inv = REG_WDATA_I[ISU_ADDR_INV_BIT];
    end

    // a single interrupt per sample: remembers that it was already raised,
    // so a valid flag left set by slow software cannot raise a second request
    always_comb
    begin
        next_irq_pend_done = irq_pend_done;
        next_miss_seen = miss_seen;
        if (state == ISU_WAIT && OP_RETIRE_I)
        begin
            next_miss_seen = OP_MISS_I;
            next_irq_pend_done = 1'b0;
        end
        else if (op_val)
            next_irq_pend_done = 1'b1;
    end

    // register read port: answer one cycle after the strobe
    always_comb
    begin
        next_rdata = rdata;
        next_ack = REG_RD_I || REG_WR_I;
        next_err = 1'b0;
        if (REG_RD_I)
        begin
            // reads have no side effect, so a repeated read is harmless
            unique case (REG_IDX_I)
                ISU_REG_FETCH_LIN: next_rdata = f_lin;
                ISU_REG_FETCH_PHY: next_rdata = {12'h0, f_phys};
                ISU_REG_OP_CTL: next_rdata = ctl_view;
                ISU_REG_OP_LIN: next_rdata = op_lin;
                ISU_REG_FETCH_STAT:
                begin
                    next_rdata = 64'h0;
                    next_rdata[ISU_FETCH_VAL_BIT] = f_val;
                    next_rdata[ISU_FETCH_PVAL_BIT] = f_pval;
                end
                ISU_REG_OP_DATA1:
                begin
                    next_rdata = 64'h0;
                    next_rdata[ISU_ADDR_INV_BIT] = addr_inv;
                end
                default:
                begin
                    next_rdata = 64'h0;
                    next_err = 1'b1;
                end
            endcase
        end
        // writes to read-only or unmapped indexes are refused with err
        else if (REG_WR_I && (REG_IDX_I == ISU_REG_FETCH_LIN
            || REG_IDX_I == ISU_REG_FETCH_PHY || REG_IDX_I > ISU_REG_OP_DATA1))
            next_err = 1'b1;
    end

    // all state registers; reset leaves sampling off
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            state <= ISU_COUNT;
            cnt <= 27'h0;
            max_cnt <= 23'h0;
            src <= 1'b0;
            op_val <= 1'b0;
            op_en <= 1'b0;
            miss_only <= 1'b0;
            op_lin <= 64'h0;
            addr_inv <= 1'b0;
            tag <= 1'b0;
            irq <= 1'b0;
            rdata <= 64'h0;
            ack <= 1'b0;
            err <= 1'b0;
            // no sample is pending, so no request is owed
            irq_pend_done <= 1'b0;
            miss_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            max_cnt <= next_max_cnt;
            src <= next_src;
            op_val <= next_op_val;
            op_en <= next_op_en;
            miss_only <= next_miss_only;
            op_lin <= next_op_lin;
            addr_inv <= next_addr_inv;
            tag <= next_tag;
            irq <= next_irq;
            rdata <= next_rdata;
            ack <= next_ack;
            err <= next_err;
            irq_pend_done <= next_irq_pend_done;
            miss_seen <= next_miss_seen;
        end
    end

    // every output is a register, so the far side sees no glitches
    assign REG_RDATA_O = rdata;
    assign REG_ACK_O = ack;
    assign REG_ERR_O = err;
    assign OP_TAG_O = tag;
    assign IRQ_O = irq;
endmodule

//--- design/isu_pkg.sv
package isu_pkg;
    // register indexes on the model-specific register port (arbitrary block-local choice)
    localparam logic [2:0] ISU_REG_FETCH_LIN = 3'h0;
    localparam logic [2:0] ISU_REG_FETCH_PHY = 3'h1;
    localparam logic [2:0] ISU_REG_OP_CTL = 3'h2;
    localparam logic [2:0] ISU_REG_OP_LIN = 3'h3;
    localparam logic [2:0] ISU_REG_FETCH_STAT = 3'h4;
    localparam logic [2:0] ISU_REG_OP_DATA1 = 3'h5;
    // control register field positions
    localparam int ISU_CUR_LSB = 32;
    localparam int ISU_CUR_MSB = 58;
    localparam int ISU_MAXHI_LSB = 20;
    localparam int ISU_MAXHI_MSB = 26;
    localparam int ISU_SRC_BIT = 19;
    localparam int ISU_VAL_BIT = 18;
    localparam int ISU_EN_BIT = 17;
    localparam int ISU_MISS_BIT = 16;
    localparam int ISU_MAXLO_MSB = 15;
    // fetch status and op data bits
    localparam int ISU_FETCH_PVAL_BIT = 52;
    localparam int ISU_FETCH_VAL_BIT = 49;
    localparam int ISU_ADDR_INV_BIT = 38;
    // widths
    localparam int ISU_CNT_W = 27;
    localparam int ISU_MAX_W = 23;
    localparam int ISU_PHYS_W = 52;
    localparam logic [6:0] ISU_LFSR_SEED = 7'h5B;
    // op tracking states, gray coded
    typedef enum logic [1:0] {
        ISU_COUNT = 2'b00,
        ISU_TAG = 2'b01,
        ISU_WAIT = 2'b11
    } isu_state_t;
endpackage

//--- design/isu_lfsr.sv
`timescale 1ns/1ns
// 7-bit pseudo-random source for abort reloads
module isu_lfsr
    import isu_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    output logic [6:0] value_o
);
    logic [6:0] state;
    logic [6:0] next_state;

    // x^7 + x^6 + 1, steps every cycle so the value drifts freely
    always_comb
    begin
        next_state = {state[5:0], state[6] ^ state[5]};
    end

    // seed is a constant so the lfsr never locks at zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state <= ISU_LFSR_SEED;
        else
            state <= next_state;
    end

    assign value_o = state;
endmodule

//--- design/isu_capture.sv
`timescale 1ns/1ns
// fetch sample capture: linear and physical address plus its two flags
module isu_capture
    import isu_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic done_i,
    input wire logic phys_ok_i,
    input wire logic [63:0] lin_i,
    input wire logic [51:0] phys_i,
    input wire logic clear_i,
    output logic [63:0] lin_o,
    output logic [51:0] phys_o,
    output logic valid_o,
    output logic phys_valid_o
);
    logic [63:0] lin;
    logic [51:0] phys;
    logic valid;
    logic pval;
    logic [63:0] next_lin;
    logic [51:0] next_phys;
    logic next_valid;
    logic next_pval;

    // a completed or aborted fetch lands here; a fetch beats a clear
    always_comb
    begin
        next_lin = lin;
        next_phys = phys;
        next_valid = valid;
        next_pval = pval;
        if (clear_i)
        begin
            next_valid = 1'b0;
            next_pval = 1'b0;
        end
        if (done_i && (!valid || clear_i))
        begin
            next_lin = lin_i;
            next_phys = phys_i;
            next_valid = 1'b1;
            next_pval = phys_ok_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lin <= 64'h0;
            phys <= 52'h0;
            valid <= 1'b0;
            pval <= 1'b0;
        end
        else
        begin
            lin <= next_lin;
            phys <= next_phys;
            valid <= next_valid;
            pval <= next_pval;
        end
    end

    assign lin_o = lin;
    assign phys_o = phys;
    assign valid_o = valid;
    assign phys_valid_o = pval;
endmodule

//--- bench/isu_core_model.sv
`timescale 1ns/1ns
// pipeline stand-in: answers each tag with one retire or one abort
module isu_core_model
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic tag_i,
    input wire logic abort_mode_i,
    input wire logic [3:0] delay_i,
    input wire logic disp_i,
    input wire logic miss_i,
    input wire logic bad_i,
    input wire logic [63:0] lin_i,
    output logic dispatch_o,
    output logic retire_o,
    output logic abort_o,
    output logic miss_o,
    output logic bad_o,
    output logic [63:0] lin_o
);
    logic [4:0] wait_cnt; // cycles left before the answer, zero when idle
    // status lines carry data only with retire; otherwise a changed value,
    // so a design that samples them late cannot match by luck
    assign miss_o = retire_o ? miss_i : ~miss_i;
    assign bad_o = retire_o ? bad_i : ~bad_i;
    assign lin_o = retire_o ? lin_i : ~lin_i;
    // one answer per tag, after a delay the bench varies
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_cnt <= 5'h00;
            retire_o <= 1'b0;
            abort_o <= 1'b0;
            dispatch_o <= 1'b0;
        end
        else
        begin
            dispatch_o <= disp_i;
            retire_o <= wait_cnt == 5'h01 && !abort_mode_i;
            abort_o <= wait_cnt == 5'h01 && abort_mode_i;
            if (tag_i)
                wait_cnt <= {1'b0, delay_i} + 5'h01;
            else if (wait_cnt != 5'h00)
                wait_cnt <= wait_cnt - 5'h01;
        end
    end
endmodule

//--- bench/isu_top_properties.sv
`timescale 1ns/1ns
// register port, tag and interrupt timing of isu_top
module isu_top_properties
    import isu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic REG_RD_I,
    input wire logic REG_WR_I,
    input wire logic [2:0] REG_IDX_I,
    input wire logic [63:0] REG_RDATA_O,
    input wire logic REG_ACK_O,
    input wire logic REG_ERR_O,
    input wire logic OP_RETIRE_I,
    input wire logic OP_ABORT_I,
    input wire logic OP_TAG_O,
    input wire logic IRQ_O
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);
    // any register access this cycle
    wire logic req = REG_RD_I || REG_WR_I;
    a_ack_follows_req: assert property (req |=> REG_ACK_O)
        else $error("no ack after register access");
    a_ack_has_cause: assert property (REG_ACK_O |-> $past(req))
        else $error("ack without access");
    a_ro_write_err: assert property (REG_WR_I && REG_IDX_I < 3'h2 |=> REG_ERR_O)
        else $error("write to read-only register not refused");
    a_err_only_bad: assert property (REG_ERR_O |-> REG_ACK_O
        && ($past(REG_IDX_I) > 3'h5 || $past(REG_WR_I) && $past(REG_IDX_I) < 3'h2))
        else $error("error on a legal access");
    a_phys_upper_zero: assert property (REG_ACK_O
        && $past(REG_RD_I && REG_IDX_I == ISU_REG_FETCH_PHY) |-> REG_RDATA_O[63:52] == 12'h000)
        else $error("physical address upper bits not zero");
    a_irq_after_retire: assert property (IRQ_O |-> $past(OP_RETIRE_I, 2))
        else $error("interrupt not two cycles after retire");
    a_no_irq_abort: assert property (OP_ABORT_I |-> ##2 !IRQ_O)
        else $error("interrupt after abort");
    a_irq_single: assert property (IRQ_O |=> !IRQ_O [*3])
        else $error("interrupt repeated");
    a_tag_single: assert property (OP_TAG_O |=> !OP_TAG_O)
        else $error("tag longer than one cycle");
    a_reset_quiet: assert property ($rose(RESETN_I) |-> !IRQ_O && !OP_TAG_O && !REG_ACK_O)
        else $error("outputs active after reset");
    c_irq: cover property (IRQ_O);
    c_tag: cover property (OP_TAG_O);
    c_err: cover property (REG_ERR_O);
    c_abort: cover property (OP_ABORT_I);
endmodule
bind isu_top isu_top_properties u_props (
    .CLK_I(CLK_I),
    .RESETN_I(RESETN_I),
    .REG_RD_I(REG_RD_I),
    .REG_WR_I(REG_WR_I),
    .REG_IDX_I(REG_IDX_I),
    .REG_RDATA_O(REG_RDATA_O),
    .REG_ACK_O(REG_ACK_O),
    .REG_ERR_O(REG_ERR_O),
    .OP_RETIRE_I(OP_RETIRE_I),
    .OP_ABORT_I(OP_ABORT_I),
    .OP_TAG_O(OP_TAG_O),
    .IRQ_O(IRQ_O)
);

//--- bench/testbench.sv
`timescale 1ns/1ns
// plays software and the fetch side; the core model plays the op pipeline
module testbench
    import isu_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [63:0] wdata = 64'h0;
    logic [63:0] flin = 64'h0;
    logic [51:0] fphys = 52'h0;
    logic fdone = 1'b0;
    logic pok = 1'b0;
    logic disp = 1'b0;
    logic amode = 1'b0;
    logic miss = 1'b0;
    logic bad = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [63:0] olin = 64'h0;
    logic [63:0] rdata, lin_w;
    logic ack, err, tag, irq, dispatch, retire, abort, miss_w, bad_w;
    logic [63:0] r = 64'h47; // random source state, fixed start
    int miscompares = 0;
    int total_checks = 0;
    isu_top DUT (.CLK_I(clk), .RESETN_I(rst_n), .REG_RD_I(rd), .REG_WR_I(wr),
        .REG_IDX_I(idx), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
        .REG_ERR_O(err), .FETCH_DONE_I(fdone), .FETCH_PHYS_OK_I(pok),
        .FETCH_LIN_I(flin), .FETCH_PHYS_I(fphys), .OP_DISPATCH_I(dispatch),
        .OP_RETIRE_I(retire), .OP_ABORT_I(abort), .OP_MISS_I(miss_w),
        .OP_ADDR_BAD_I(bad_w), .OP_LIN_I(lin_w), .OP_TAG_O(tag), .IRQ_O(irq));
    isu_core_model u_core (.clk_i(clk), .resetn_i(rst_n), .tag_i(tag),
        .abort_mode_i(amode), .delay_i(dly), .disp_i(disp), .miss_i(miss),
        .bad_i(bad), .lin_i(olin), .dispatch_o(dispatch), .retire_o(retire),
        .abort_o(abort), .miss_o(miss_w), .bad_o(bad_w), .lin_o(lin_w));
    // 64-bit shift register, eight steps per draw so draws differ widely
    function automatic logic [63:0] step(input logic [63:0] s);
        logic [63:0] t;
        t = s;
        for (int b = 0; b < 8; b++)
            t = {t[62:0], t[63] ^ t[62] ^ t[60] ^ t[59]};
        return t;
    endfunction
    // interrupt expected: retired, and either unfiltered or a miss
    function automatic logic exp_irq(input logic a, input logic f, input logic m);
        return !a && (!f || m);
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // count of ticks must fall inside a window
    task automatic chk_win(input int n, input int lo, input int hi);
        total_checks++;
        if (n < lo || n > hi)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, n, lo);
        end
    endtask
    // one register access; strobe is a single-cycle pulse, answer a cycle later
    task automatic access(input logic w, input logic [2:0] i, input logic [63:0] d,
        input logic e);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        idx <= i;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        chk({63'h0, ack}, 64'h1);
        chk({63'h0, err}, {63'h0, e});
    endtask
    task automatic summarize();
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        forever #2 clk = ~clk;
    end
    // hang guard, well beyond the longest expected run
    initial
    begin
        #100000;
        miscompares++;
        summarize();
    end
    initial
    begin
        int ticks;
        int off;
        logic seen;
        logic [26:0] cur;
        logic [22:0] mx;
        logic [63:0] fl;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        access(1'b0, ISU_REG_OP_CTL, 64'h0, 1'b0);
        chk(rdata, 64'h0);
        // fetch capture; inputs change right after so late sampling shows
        r = step(r);
        fl = r;
        @(posedge clk);
        fdone <= 1'b1;
        pok <= 1'b1;
        flin <= fl;
        fphys <= ~fl[51:0];
        @(posedge clk);
        fdone <= 1'b0;
        pok <= 1'b0;
        flin <= ~fl;
        access(1'b1, ISU_REG_FETCH_LIN, r, 1'b1);
        access(1'b0, ISU_REG_FETCH_LIN, 64'h0, 1'b0);
        chk(rdata, fl);
        access(1'b0, ISU_REG_FETCH_PHY, 64'h0, 1'b0);
        chk(rdata, {12'h000, ~fl[51:0]});
        access(1'b0, ISU_REG_FETCH_STAT, 64'h0, 1'b0);
        chk({62'h0, rdata[52], rdata[49]}, 64'h3);
        access(1'b0, 3'h6, 64'h0, 1'b1);
        access(1'b1, 3'h7, r, 1'b1);
        // clear and a new fetch on one edge: the new fetch must win
        r = step(r);
        @(posedge clk);
        fdone <= 1'b1;
        flin <= r;
        wr <= 1'b1;
        idx <= ISU_REG_FETCH_STAT;
        wdata <= 64'h0;
        @(posedge clk);
        fdone <= 1'b0;
        wr <= 1'b0;
        access(1'b0, ISU_REG_FETCH_LIN, 64'h0, 1'b0);
        chk(rdata, r);
        access(1'b0, ISU_REG_FETCH_STAT, 64'h0, 1'b0);
        chk({62'h0, rdata[52], rdata[49]}, 64'h1);
        access(1'b1, ISU_REG_FETCH_STAT, 64'h0, 1'b0);
        access(1'b0, ISU_REG_FETCH_STAT, 64'h0, 1'b0);
        chk(rdata, 64'h0);
        // op rows: bit0 counts dispatches, bit1 miss filter, bit2 abort
        for (int k = 0; k < 6; k++)
        begin
            r = step(r);
            off = 8 + int'(r[3:0]);
            mx = k[0] ? 23'h000003 : 23'h010000;
            cur = {mx, 4'h0} - 27'(off);
            amode <= k[2];
            miss <= r[8];
            bad <= r[9];
            olin <= r;
            dly <= r[13:10];
            access(1'b1, ISU_REG_OP_CTL, {5'h0, cur, 5'h0, mx[22:16], k[0], 2'b01,
                k[1], mx[15:0]}, 1'b0);
            ticks = 0;
            while (tag !== 1'b1 && ticks < 400)
            begin
                @(posedge clk);
                ticks += k[0] ? int'(dispatch) : 1;
                r = step(r);
                disp <= r[0] & k[0];
            end
            disp <= 1'b0;
            chk_win(ticks, off - 1, off + 4);
            seen = 1'b0;
            repeat (30)
            begin
                @(posedge clk);
                #1;
                seen |= irq;
            end
            chk({63'h0, seen}, {63'h0, exp_irq(k[2], k[1], miss)});
            access(1'b0, ISU_REG_OP_CTL, 64'h0, 1'b0);
            chk({63'h0, rdata[ISU_VAL_BIT]}, {63'h0, !k[2]});
            cur = rdata[58:32];
            if (k[2])
                chk({45'h0, rdata[58:40]}, 64'h0);
            else
            begin
                access(1'b0, ISU_REG_OP_LIN, 64'h0, 1'b0);
                chk(rdata, olin);
                access(1'b0, ISU_REG_OP_DATA1, 64'h0, 1'b0);
                chk({63'h0, rdata[ISU_ADDR_INV_BIT]}, {63'h0, bad});
                access(1'b0, ISU_REG_OP_CTL, 64'h0, 1'b0);
                chk({37'h0, rdata[58:32]}, {37'h0, cur});
            end
            // sample saved, so clearing valid is safe now
            access(1'b1, ISU_REG_OP_CTL, 64'h0, 1'b0);
        end
        // software may restore the address and its invalid flag
        access(1'b1, ISU_REG_OP_LIN, r, 1'b0);
        access(1'b0, ISU_REG_OP_LIN, 64'h0, 1'b0);
        chk(rdata, r);
        access(1'b1, ISU_REG_OP_DATA1, 64'h0000_0040_0000_0000, 1'b0);
        access(1'b0, ISU_REG_OP_DATA1, 64'h0, 1'b0);
        chk(rdata, 64'h0000_0040_0000_0000);
        // disabled counter must not move from its loaded start
        access(1'b1, ISU_REG_OP_CTL, 64'h0000_0005_0000_0000, 1'b0);
        repeat (10) @(posedge clk);
        access(1'b0, ISU_REG_OP_CTL, 64'h0, 1'b0);
        chk(rdata, 64'h0000_0005_0000_0000);
        summarize();
    end
endmodule
